// >>> common/sps_pkg.sv
// Constants and state type for the byte-wide serial port.
// How it works
// - Slave with select low drives only data-out.
// - Select high resets slave counter, drops partial.
// - Master output select pin is plain output.
// - Low select input forces slave, sets flag.
// - Interrupt when enabled, flag set, global enable.
// - Port enable bit gates every transfer.
// - Bit order one sends LSB first.
// - Role bit one master, zero slave.
// - Polarity bit sets serial clock idle level.
// - Phase bit picks sample or setup edge.
// - Rate bits and doubling pick clock divisor.
// - Rate bits ignored in slave role.
// - Transfer done flag set after each byte.
// - Flag cleared by vector or status-data sequence.
// - Data write mid-transfer sets collision flag.
// - Status bits five to one read zero.
// - Double rate gives two-cycle shortest period.
// - Data write starts send, read returns buffer.
// - Master shifts eight bits then stops clock.
// - Single buffered send, double buffered receive.
`default_nettype none
package sps_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA   = 8'h08;
	localparam logic [7:0] ADDR_PINDIR = 8'h0C;
	localparam int CTRL_IE    = 7;
	localparam int CTRL_EN    = 6;
	localparam int CTRL_ORDER = 5;
	localparam int CTRL_ROLE  = 4;
	localparam int CTRL_CLOCK_IDLE_POLARITY  = 3;
	localparam int CTRL_CLOCK_SAMPLE_PHASE  = 2;
	localparam int STAT_DONE  = 7;
	localparam int STAT_COL   = 6;
	localparam int STAT_DBL   = 0;
	localparam int DIR_MOSI   = 0;
	localparam int DIR_MISO   = 1;
	localparam int DIR_SCK    = 2;
	localparam int DIR_SS     = 3;
	localparam int DIR_SSLVL  = 4;
	localparam int SYNC_MOSI  = 0;
	localparam int SYNC_MISO  = 1;
	localparam int SYNC_SCK   = 2;
	localparam int SYNC_SS    = 3;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [4:0] PINDIR_RESET = 5'h00;
	localparam logic [3:0] SYNC_RESET   = 4'hF;
	localparam logic [6:0] HALF_DIV4   = 7'h02;
	localparam logic [6:0] HALF_DIV16  = 7'h08;
	localparam logic [6:0] HALF_DIV64  = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
	localparam logic [6:0] HALF_DIV2   = 7'h01;
	localparam logic [6:0] HALF_DIV8   = 7'h04;
	localparam logic [6:0] HALF_DIV32  = 7'h10;
	localparam logic [4:0] LAST_EDGE   = 5'h0F;
	localparam logic [3:0] LAST_BIT    = 4'h7;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [31:0] rdata;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [7:0]  rsel;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        aw_held;
		logic [7:0]  awaddr;
		logic        w_held;
		logic [7:0]  wdata;
		logic        wstrb0;
		logic [7:0]  ctrl;
		logic        dbl;
		logic        flag;
		logic        col;
		logic        flag_arm;
		logic        col_arm;
		logic [4:0]  pdir;
		logic [7:0]  sh;
		logic [7:0]  rbuf;
		logic        dout;
		logic        sck;
		logic        busy;
		logic [4:0]  edges;
		logic [3:0]  bits;
		logic [6:0]  divc;
		logic [3:0]  sync1;
		logic [3:0]  sync2;
		logic        sck_prev;
	} sps_state_type;
endpackage
`default_nettype wire

// >>> rtl/sps_port.sv
// Byte-wide master or slave serial port with an AXI4-Lite register slave.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module sps_port (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        global_irq_en,
	input  wire logic        irq_ack,
	output logic             irq,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe
);
	sps_pkg::sps_state_type s_q;
	sps_pkg::sps_state_type s_d;
	logic       en;
	logic       master;
	logic       ss_s;
	logic       done_evt;
	logic       col_evt;
	logic       fault_evt;
	logic       wr_data;
	logic       rd_data;

	assign en     = s_q.ctrl[sps_pkg::CTRL_EN];
	assign master = s_q.ctrl[sps_pkg::CTRL_ROLE];
	assign ss_s   = s_q.sync2[sps_pkg::SYNC_SS];

	function automatic logic out_bit(input logic [7:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[7];
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb, input logic b);
		shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction

	always_comb begin
		logic [6:0] half;
		logic       lsb;
		logic       samp;
		logic       setup;
		logic       chg;
		logic       sck_s;
		logic [7:0] sh_n;
		half = sps_pkg::HALF_DIV4;
		lsb = s_q.ctrl[sps_pkg::CTRL_ORDER];
		samp = 1'b0;
		setup = 1'b0;
		chg = 1'b0;
		sck_s = s_q.sync2[sps_pkg::SYNC_SCK];
		sh_n = 8'h00;
		s_d = s_q;
		done_evt = 1'b0;
		col_evt = 1'b0;
		fault_evt = 1'b0;
		wr_data = 1'b0;
		rd_data = 1'b0;
		// Two flip-flops on every pin input before any logic reads it.
		s_d.sync1 = {ss_n_i, sck_i, miso_i, mosi_i};
		s_d.sync2 = s_q.sync1;
		s_d.sck_prev = sck_s;

		// Write channel: address and data are taken in either order.
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_axi_awvalid && !s_q.aw_held) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !s_q.w_held) begin
			s_d.w_held = 1'b1;
			s_d.wdata = s_axi_wdata[7:0];
			s_d.wstrb0 = s_axi_wstrb[0];
		end
		if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = sps_pkg::RESP_OKAY;
			case (s_q.awaddr)
				sps_pkg::ADDR_CTRL: begin
					if (s_q.wstrb0) begin
						s_d.ctrl = s_q.wdata;
					end
				end
				sps_pkg::ADDR_STATUS: begin
					if (s_q.wstrb0) begin
						s_d.dbl = s_q.wdata[sps_pkg::STAT_DBL];
					end
				end
				sps_pkg::ADDR_DATA: begin
					wr_data = s_q.wstrb0;
				end
				sps_pkg::ADDR_PINDIR: begin
					if (s_q.wstrb0) begin
						s_d.pdir = s_q.wdata[4:0];
					end
				end
				default: begin
					s_d.bresp = sps_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Read channel with one read outstanding at a time.
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end else if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rsel = s_axi_araddr[7:0];
			s_d.rresp = sps_pkg::RESP_OKAY;
			s_d.rdata = 32'h0000_0000;
			case (s_axi_araddr[7:0])
				sps_pkg::ADDR_CTRL: begin
					s_d.rdata[7:0] = s_q.ctrl;
				end
				sps_pkg::ADDR_STATUS: begin
					s_d.rdata[7:0] = {s_q.flag, s_q.col, 5'h00, s_q.dbl};
					s_d.flag_arm = s_q.flag;
					s_d.col_arm = s_q.col;
				end
				sps_pkg::ADDR_DATA: begin
					s_d.rdata[7:0] = s_q.rbuf;
					rd_data = 1'b1;
				end
				sps_pkg::ADDR_PINDIR: begin
					s_d.rdata[4:0] = s_q.pdir;
				end
				default: begin
					s_d.rresp = sps_pkg::RESP_SLVERR;
				end
			endcase
		end

		// A data access after an armed status read clears the flags.
		if (wr_data || rd_data) begin
			if (s_q.flag_arm || s_q.col_arm) begin
				s_d.flag = 1'b0;
			end
			if (s_q.col_arm) begin
				s_d.col = 1'b0;
			end
			s_d.flag_arm = 1'b0;
			s_d.col_arm = 1'b0;
		end
		if (irq_ack) begin
			s_d.flag = 1'b0;
		end

		// A write while a byte is moving collides and is dropped.
		if (wr_data) begin
			if (s_q.busy || (!master && s_q.bits != 4'h0)) begin
				col_evt = 1'b1;
			end else begin
				s_d.sh = s_q.wdata;
				if (en && master) begin
					s_d.busy = 1'b1;
					s_d.edges = 5'h00;
					s_d.divc = 7'h00;
					s_d.dout = out_bit(s_q.wdata, lsb);
				end
			end
		end

		case ({s_q.dbl, s_q.ctrl[1:0]})
			3'h0: half = sps_pkg::HALF_DIV4;
			3'h1: half = sps_pkg::HALF_DIV16;
			3'h2: half = sps_pkg::HALF_DIV64;
			3'h3: half = sps_pkg::HALF_DIV128;
			3'h4: half = sps_pkg::HALF_DIV2;
			3'h5: half = sps_pkg::HALF_DIV8;
			3'h6: half = sps_pkg::HALF_DIV32;
			default: half = sps_pkg::HALF_DIV64;
		endcase

		if (!en) begin
			s_d.busy = 1'b0;
			s_d.bits = 4'h0;
		end else if (master) begin
			if (!s_q.pdir[sps_pkg::DIR_SS] && !ss_s) begin
				fault_evt = 1'b1;
				s_d.ctrl[sps_pkg::CTRL_ROLE] = 1'b0;
				s_d.busy = 1'b0;
				s_d.bits = 4'h0;
			end else if (s_q.busy) begin
				if (s_q.divc == half - 7'h01) begin
					s_d.divc = 7'h00;
					s_d.sck = ~s_q.sck;
					s_d.edges = s_q.edges + 5'h01;
					// Even edges lead; the phase bit picks which edge samples.
					// Sampled data lags two cycles, so correct reception needs
					// a half period of at least three system clock cycles.
					samp = s_q.edges[0] == s_q.ctrl[sps_pkg::CTRL_CLOCK_SAMPLE_PHASE];
					if (samp) begin
						sh_n = shift_in(s_q.sh, lsb, s_q.sync2[sps_pkg::SYNC_MISO]);
						s_d.sh = sh_n;
					end else begin
						s_d.dout = out_bit(s_q.sh, lsb);
					end
					if (s_q.edges == sps_pkg::LAST_EDGE) begin
						s_d.busy = 1'b0;
						s_d.rbuf = s_d.sh;
						done_evt = 1'b1;
					end
				end else begin
					s_d.divc = s_q.divc + 7'h01;
				end
			end else begin
				s_d.sck = s_q.ctrl[sps_pkg::CTRL_CLOCK_IDLE_POLARITY];
			end
		end else begin
			s_d.busy = 1'b0;
			if (ss_s) begin
				s_d.bits = 4'h0;
			end else begin
				chg = sck_s != s_q.sck_prev;
				samp = chg && ((sck_s != s_q.ctrl[sps_pkg::CTRL_CLOCK_IDLE_POLARITY])
					!= s_q.ctrl[sps_pkg::CTRL_CLOCK_SAMPLE_PHASE]);
				setup = chg && !samp;
				if (samp) begin
					sh_n = shift_in(s_q.sh, lsb, s_q.sync2[sps_pkg::SYNC_MOSI]);
					s_d.sh = sh_n;
					s_d.bits = s_q.bits + 4'h1;
					if (s_q.bits == sps_pkg::LAST_BIT) begin
						s_d.bits = 4'h0;
						s_d.rbuf = sh_n;
						done_evt = 1'b1;
					end
				end
			end
			if (!samp && (setup || s_q.bits == 4'h0) && !wr_data) begin
				s_d.dout = out_bit(s_q.sh, lsb);
			end
		end

		// Hardware sets win over any clear in the same cycle.
		if (done_evt || fault_evt) begin
			s_d.flag = 1'b1;
		end
		if (col_evt) begin
			s_d.col = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ctrl <= sps_pkg::CTRL_RESET;
			s_q.pdir <= sps_pkg::PINDIR_RESET;
			s_q.sync1 <= sps_pkg::SYNC_RESET;
			s_q.sync2 <= sps_pkg::SYNC_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = !s_q.aw_held;
	assign s_axi_wready  = !s_q.w_held;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign irq     = s_q.ctrl[sps_pkg::CTRL_IE] & s_q.flag & global_irq_en;
	assign sck_o   = s_q.sck;
	assign sck_oe  = en & master & s_q.pdir[sps_pkg::DIR_SCK];
	assign mosi_o  = s_q.dout;
	assign mosi_oe = en & master & s_q.pdir[sps_pkg::DIR_MOSI];
	assign miso_o  = s_q.dout;
	assign miso_oe = en & !master & !ss_s & s_q.pdir[sps_pkg::DIR_MISO];
	assign ss_n_o  = s_q.pdir[sps_pkg::DIR_SSLVL];
	assign ss_n_oe = master & s_q.pdir[sps_pkg::DIR_SS];

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_mode_fault: assert property (en && master && !s_q.pdir[sps_pkg::DIR_SS] && !ss_s
		|=> !master && s_q.flag && !s_q.busy)
		else $error("Mode fault did not force slave role.");
	a_slave_reset: assert property (en && !master && ss_s |=> s_q.bits == 4'h0)
		else $error("Slave counter not cleared by high select.");
	a_miso_drive: assert property (miso_oe |-> en && !master && !ss_s)
		else $error("Data-out driven outside selected slave.");
	a_ss_gpio: assert property (master && s_q.pdir[sps_pkg::DIR_SS]
		|-> ss_n_oe && ss_n_o == s_q.pdir[sps_pkg::DIR_SSLVL] && !fault_evt)
		else $error("Output select pin affected the port.");
	a_irq_raise: assert property ($rose(s_q.flag) && s_q.ctrl[sps_pkg::CTRL_IE]
		&& global_irq_en |-> irq)
		else $error("Interrupt missing on done flag.");
	a_disabled_idle: assert property (!en |=> !s_q.busy && s_q.bits == 4'h0)
		else $error("Transfer ran while port disabled.");
	a_sck_idle: assert property (en && master && !s_q.busy && !$past(s_q.busy)
		&& $stable(s_q.ctrl) |-> s_q.sck == s_q.ctrl[sps_pkg::CTRL_CLOCK_IDLE_POLARITY])
		else $error("Serial clock not at idle level.");
	a_master_done: assert property (s_q.busy && master && en && s_q.edges == sps_pkg::LAST_EDGE
		&& s_d.divc == 7'h00 && s_q.divc != 7'h00 |=> !s_q.busy && s_q.flag)
		else $error("Master byte did not finish after sixteen edges.");
	a_fast_half: assert property (s_q.busy && s_q.dbl && s_q.ctrl[1:0] == 2'h0
		&& !$past(wr_data) |-> s_q.sck != $past(s_q.sck))
		else $error("Double rate clock not toggling every cycle.");
	a_collision: assert property (wr_data && s_q.busy |=> s_q.col)
		else $error("Collision flag not set.");
	a_rx_hold: assert property (!$stable(s_q.rbuf) |-> $past(done_evt))
		else $error("Receive buffer changed without a finished byte.");
	a_reserved_zero: assert property (s_q.rvalid && s_q.rsel == sps_pkg::ADDR_STATUS
		|-> s_q.rdata[5:1] == 5'h00)
		else $error("Reserved status bits not zero.");

	a_write_start: assert property (wr_data && !col_evt && en && master
		&& (s_q.pdir[sps_pkg::DIR_SS] || ss_s) |=> s_q.busy)
		else $error("Master data write did not start a byte.");
	a_slave_rate: assert property (en && !master |=> $stable(s_q.divc) && $stable(s_q.edges))
		else $error("Rate divider moved in slave role.");
	a_done_set: assert property (done_evt |=> s_q.flag)
		else $error("Done flag not set after a byte.");
	a_flag_ack: assert property (irq_ack && !done_evt && !fault_evt |=> !s_q.flag)
		else $error("Done flag not cleared by vector acknowledge.");
	a_col_clear: assert property ((wr_data || rd_data) && s_q.col_arm && !col_evt
		&& !done_evt && !fault_evt |=> !s_q.col && !s_q.flag)
		else $error("Collision and done flags not cleared by data access.");
	a_slave_inputs: assert property (en && !master |-> !sck_oe && !mosi_oe && !ss_n_oe)
		else $error("Pin driven in slave role other than data-out.");
	a_lsb_first: assert property (wr_data && !col_evt && en && master
		&& s_q.ctrl[sps_pkg::CTRL_ORDER] |=> s_q.dout == $past(s_q.wdata[0]))
		else $error("Least significant bit not sent first.");
	a_disabled_pins: assert property (!en |-> !sck_oe && !mosi_oe && !miso_oe)
		else $error("Serial pin driven while port disabled.");
	a_slave_passive: assert property (en && !master && ss_s |=> $stable(s_q.rbuf))
		else $error("Deselected slave accepted data.");

	c_master_byte: cover property (master && done_evt);
	c_slave_byte: cover property (!master && done_evt);
	c_mode_fault: cover property (fault_evt);
	c_collision: cover property (col_evt);
	c_lsb_byte: cover property (master && done_evt && s_q.ctrl[sps_pkg::CTRL_ORDER]);
endmodule
`default_nettype wire

// >>> test/sps_port_test.sv
// Self-checking bench for the byte-wide serial port.
`default_nettype none
module sps_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] AC = sps_pkg::ADDR_CTRL;
	localparam logic [7:0] AS = sps_pkg::ADDR_STATUS;
	localparam logic [7:0] AD = sps_pkg::ADDR_DATA;
	localparam logic [7:0] AP = sps_pkg::ADDR_PINDIR;
	localparam int         HALF [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, gie, ack;
	logic [31:0] awaddr, wdata, araddr, rdata, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
	logic        r_sck, r_sck_en, r_ss, r_ss_en, r_dout, r_mosi_en, r_miso_en, r_clock_idle_polarity, r_clock_sample_phase;
	wire logic   sck_w, mosi_w, miso_w, ss_w;
	int          err_count, checked, n;
	// Select and data lines are pulled up, the clock line pulled down.
	assign sck_w = sck_oe ? sck_o : (r_sck_en ? r_sck : 1'b0);
	assign mosi_w = mosi_oe ? mosi_o : (r_mosi_en ? r_dout : 1'b1);
	assign miso_w = miso_oe ? miso_o : (r_miso_en ? r_dout : 1'b1);
	assign ss_w = ss_oe ? ss_o : (r_ss_en ? r_ss : 1'b1);
	sps_port u_sps_port (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.global_irq_en(gie), .irq_ack(ack), .irq(irq), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w),
		.ss_n_o(ss_o), .ss_n_oe(ss_oe)
	);
	sps_remote u_sps_remote (
		.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(miso_w), .clock_idle_polarity(r_clock_idle_polarity),
		.clock_sample_phase(r_clock_sample_phase), .sck_d(r_sck), .sck_en(r_sck_en), .ss_d(r_ss), .ss_en(r_ss_en),
		.dout(r_dout), .mosi_en(r_mosi_en), .miso_en(r_miso_en)
	);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		logic ta, tw, tb;
		awaddr <= {24'h0, a};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			if (tb) chkr(bresp, e);
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
		logic ta, tr;
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			e = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd(a, v, r);
		chk(v, exp);
	endtask
	task automatic wait_done(input logic [31:0] exp);
		v = 32'h0;
		while (v[7] !== 1'b1) rd(AS, v, r);
		chk(v, exp);
	endtask
	task automatic half(output int cnt);
		logic s;
		s = sck_o;
		while (sck_o === s) @(negedge aclk);
		s = sck_o;
		cnt = 0;
		while (sck_o === s) begin
			@(negedge aclk);
			cnt++;
		end
		@(posedge aclk);
	endtask
	task automatic xfer(input logic [7:0] c, input logic [7:0] s, input logic [7:0] t);
		wr(AP, 8'h1D, sps_pkg::RESP_OKAY);
		wr(AC, c, sps_pkg::RESP_OKAY);
		r_clock_idle_polarity <= c[3];
		r_clock_sample_phase <= c[2];
		u_sps_remote.tx <= s;
		wr(AP, 8'h0D, sps_pkg::RESP_OKAY);
		wr(AD, t, sps_pkg::RESP_OKAY);
	endtask
	task automatic summarize();
		$display("Mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		summarize();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, gie, ack} = 8'h00;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hF;
		{r_clock_idle_polarity, r_clock_sample_phase} = 2'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(AC, 32'h0);
		rdc(AS, 32'h0);
		rd(8'h10, v, r);
		chkr(r, sps_pkg::RESP_SLVERR);
		wr(8'h10, 8'hFF, sps_pkg::RESP_SLVERR);
		wr(AS, 8'hFF, sps_pkg::RESP_OKAY);
		rdc(AS, 32'h01);
		for (int m = 0; m < 4; m++) begin
			xfer({4'h5, m[1:0], 2'h1}, 8'h35, 8'hA5);
			wait_done(32'h81);
			chk({24'h0, u_sps_remote.rx}, 32'hA5);
			rdc(AD, 32'h35);
			rdc(AS, 32'h01);
		end
		xfer(8'h71, 8'h35, 8'h1E);
		wait_done(32'h81);
		chk({24'h0, u_sps_remote.rx}, 32'h78);
		rdc(AD, 32'hAC);
		for (int k = 0; k < 8; k++) begin
			wr(AS, {7'h0, k[2]}, sps_pkg::RESP_OKAY);
			xfer({6'h14, k[1:0]}, 8'h00, 8'h00);
			half(n);
			chk(32'(n), 32'(HALF[k]));
			wait_done({24'h0, 1'b1, 6'h00, k[2]});
			rd(AD, v, r);
		end
		wr(AS, 8'h00, sps_pkg::RESP_OKAY);
		xfer(8'h53, 8'h00, 8'h11);
		wr(AD, 8'h22, sps_pkg::RESP_OKAY);
		wait_done(32'hC0);
		chk({24'h0, u_sps_remote.rx}, 32'h11);
		rd(AD, v, r);
		rdc(AS, 32'h0);
		wr(AC, 8'h10, sps_pkg::RESP_OKAY);
		wr(AD, 8'h33, sps_pkg::RESP_OKAY);
		repeat (300) @(posedge aclk);
		rdc(AS, 32'h0);
		chk({31'h0, ss_oe}, 32'h1);
		wr(AP, 8'h02, sps_pkg::RESP_OKAY);
		wr(AC, 8'h40, sps_pkg::RESP_OKAY);
		r_clock_idle_polarity <= 1'b0;
		r_clock_sample_phase <= 1'b0;
		wr(AD, 8'h5A, sps_pkg::RESP_OKAY);
		chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h0);
		u_sps_remote.frame(8'h96, 3);
		@(posedge aclk);
		rdc(AS, 32'h0);
		wr(AD, 8'h5A, sps_pkg::RESP_OKAY);
		fork
			u_sps_remote.frame(8'h0F, 8);
			#3010 chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h1);
		join
		@(posedge aclk);
		wait_done(32'h80);
		rdc(AD, 32'h0F);
		chk({24'h0, u_sps_remote.rx}, 32'h5A);
		wr(AP, 8'h05, sps_pkg::RESP_OKAY);
		wr(AC, 8'hD0, sps_pkg::RESP_OKAY);
		gie <= 1'b1;
		u_sps_remote.hold_low(1'b1);
		wait_done(32'h80);
		rdc(AC, 32'hC0);
		@(negedge aclk);
		chk({30'h0, sck_oe, mosi_oe}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		@(posedge aclk);
		gie <= 1'b0;
		@(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		@(posedge aclk);
		ack <= 1'b1;
		@(posedge aclk);
		ack <= 1'b0;
		u_sps_remote.hold_low(1'b0);
		rdc(AS, 32'h0);
		wr(AC, 8'h50, sps_pkg::RESP_OKAY);
		rdc(AC, 32'h50);
		summarize();
	end
endmodule
`default_nettype wire

// >>> test/sps_remote.sv
// Model of the remote serial device, acting as slave or as master.
`default_nettype none
module sps_remote (
	input  wire logic sck,
	input  wire logic ss_n,
	input  wire logic mosi,
	input  wire logic miso,
	input  wire logic clock_idle_polarity,
	input  wire logic clock_sample_phase,
	output logic      sck_d,
	output logic      sck_en,
	output logic      ss_d,
	output logic      ss_en,
	output logic      dout,
	output logic      mosi_en,
	output logic      miso_en
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] tx;
	logic [7:0] rx;
	logic       st;
	initial begin
		sck_d = 1'b0;
		sck_en = 1'b0;
		ss_d = 1'b1;
		ss_en = 1'b0;
		tx = 8'h00;
		rx = 8'h00;
		st = 1'b0;
	end
	assign dout = tx[7];
	assign mosi_en = ss_en;
	assign miso_en = !ss_en && !ss_n;
	always @(sck) begin
		if (!ss_n && (sck ^ clock_idle_polarity ^ clock_sample_phase)) rx = {rx[6:0], ss_en ? miso : mosi};
		else if (!ss_n) begin
			if (st || !clock_sample_phase) tx = {tx[6:0], 1'b0};
			st = 1'b1;
		end
	end
	always @(posedge ss_n) st = 1'b0;
	task automatic frame(input logic [7:0] b, input int n);
		#13;
		tx = b;
		sck_en = 1'b1;
		ss_en = 1'b1;
		ss_d = 1'b0;
		#200;
		repeat (n) begin
			sck_d = 1'b1;
			#200;
			sck_d = 1'b0;
			#200;
		end
		ss_d = 1'b1;
		#200;
		ss_en = 1'b0;
		sck_en = 1'b0;
	endtask
	task automatic hold_low(input logic lo);
		ss_en <= lo;
		ss_d <= !lo;
	endtask
endmodule
`default_nettype wire
